// *** core/gpr_pkg.sv ***
// Package for the pad register bank: map, reset values, carriers
package gpr_pkg;
  localparam int GPR_PINS = 64;
  localparam logic [31:0] GPR_BASE = 32'h8000_0000;
  localparam logic [6:0] OFF_DIR_LO = 7'h00;
  localparam logic [6:0] OFF_DIR_HI = 7'h04;
  localparam logic [6:0] OFF_OUT_LO = 7'h08;
  localparam logic [6:0] OFF_OUT_HI = 7'h0c;
  localparam logic [6:0] OFF_PEN_LO = 7'h10;
  localparam logic [6:0] OFF_PEN_HI = 7'h14;
  localparam logic [6:0] OFF_FN_Q0 = 7'h18;
  localparam logic [6:0] OFF_FN_Q1 = 7'h1c;
  localparam logic [6:0] OFF_FN_Q2 = 7'h20;
  localparam logic [6:0] OFF_FN_Q3 = 7'h24;
  localparam logic [6:0] OFF_SRC_LO = 7'h28;
  localparam logic [6:0] OFF_SRC_HI = 7'h2c;
  localparam logic [6:0] OFF_PPOL_LO = 7'h30;
  localparam logic [6:0] OFF_PPOL_HI = 7'h34;
  localparam logic [6:0] OFF_SCH_LO = 7'h38;
  localparam logic [6:0] OFF_SCH_HI = 7'h3c;
  localparam logic [6:0] OFF_HOLD_LO = 7'h40;
  localparam logic [6:0] OFF_HOLD_HI = 7'h44;
  localparam logic [6:0] OFF_OSET_LO = 7'h48;
  localparam logic [6:0] OFF_OSET_HI = 7'h4c;
  localparam logic [6:0] OFF_OCLR_LO = 7'h50;
  localparam logic [6:0] OFF_OCLR_HI = 7'h54;
  localparam logic [6:0] OFF_DSET_LO = 7'h58;
  localparam logic [6:0] OFF_DSET_HI = 7'h5c;
  localparam logic [6:0] OFF_DCLR_LO = 7'h60;
  localparam logic [6:0] OFF_DCLR_HI = 7'h64;
  localparam logic [6:0] OFF_LAST = 7'h64;
  // Keyboard interrupt lines 22..25 come up driven high
  localparam logic [63:0] RST_DIR = 64'h0000_0000_03c0_0000;
  localparam logic [63:0] RST_OUT = 64'h0000_0000_03c0_0000;
  localparam logic [63:0] RST_PEN = 64'hffff_ffff_ffff_ffff;
  localparam logic [63:0] RST_ZERO = 64'h0;
  localparam logic [1:0] FN_GPIO = 2'h0;

  typedef struct packed {
    logic sel;
    logic wr;
    logic [31:0] addr;
    logic [31:0] wdata;
  } gpr_req_t;

  typedef struct packed {
    logic [31:0] rdata;
    logic err;
  } gpr_rsp_t;

  // Per-pin pad controls, all 64 bits wide except function
  typedef struct packed {
    logic [63:0] out_en;
    logic [63:0] out_val;
    logic [63:0] pull_en;
    logic [63:0] pull_up;
    logic [63:0] schmitt;
    logic [63:0] holder;
    logic [63:0] alt_sel;
    logic [127:0] func;
  } gpr_pad_t;
endpackage : gpr_pkg

// *** core/gpr_bank.sv ***
// Pad register bank: 64-pin direction, data and pad settings
`timescale 1ns/1ns
module gpr_bank
  import gpr_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input gpr_req_t req,
  output gpr_rsp_t rsp,
  output gpr_pad_t pad
);
  logic rst_meta_r;
  logic rst_sync_r;
  logic rst_n;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end
  assign rst_n = rst_sync_r;

  logic [63:0] dir_r;
  logic [63:0] out_r;
  logic [63:0] pen_r;
  logic [63:0] src_r;
  logic [63:0] ppol_r;
  logic [63:0] sch_r;
  logic [63:0] hold_r;
  logic [127:0] fn_r;
  logic [63:0] dir_nxt;
  logic [63:0] out_nxt;

  // Address decode
  wire in_bank = req.sel &&
    (req.addr[31:7] == GPR_BASE[31:7]) &&
    (req.addr[1:0] == 2'h0) &&
    (req.addr[6:0] <= OFF_LAST);
  wire [6:0] off = req.addr[6:0];
  wire wr = in_bank && req.wr;
  wire [31:0] wd = req.wdata;

  wire w_dir_lo = wr && (off == OFF_DIR_LO);
  wire w_dir_hi = wr && (off == OFF_DIR_HI);
  wire w_out_lo = wr && (off == OFF_OUT_LO);
  wire w_out_hi = wr && (off == OFF_OUT_HI);
  wire w_pen_lo = wr && (off == OFF_PEN_LO);
  wire w_pen_hi = wr && (off == OFF_PEN_HI);
  wire w_fn0 = wr && (off == OFF_FN_Q0);
  wire w_fn1 = wr && (off == OFF_FN_Q1);
  wire w_fn2 = wr && (off == OFF_FN_Q2);
  wire w_fn3 = wr && (off == OFF_FN_Q3);
  wire w_src_lo = wr && (off == OFF_SRC_LO);
  wire w_src_hi = wr && (off == OFF_SRC_HI);
  wire w_ppol_lo = wr && (off == OFF_PPOL_LO);
  wire w_ppol_hi = wr && (off == OFF_PPOL_HI);
  wire w_sch_lo = wr && (off == OFF_SCH_LO);
  wire w_sch_hi = wr && (off == OFF_SCH_HI);
  wire w_hold_lo = wr && (off == OFF_HOLD_LO);
  wire w_hold_hi = wr && (off == OFF_HOLD_HI);
  wire w_oset_lo = wr && (off == OFF_OSET_LO);
  wire w_oset_hi = wr && (off == OFF_OSET_HI);
  wire w_oclr_lo = wr && (off == OFF_OCLR_LO);
  wire w_oclr_hi = wr && (off == OFF_OCLR_HI);
  wire w_dset_lo = wr && (off == OFF_DSET_LO);
  wire w_dset_hi = wr && (off == OFF_DSET_HI);
  wire w_dclr_lo = wr && (off == OFF_DCLR_LO);
  wire w_dclr_hi = wr && (off == OFF_DCLR_HI);

  // Set/clear masks; the plain write of a word overrides the alias
  wire [63:0] oset = {w_oset_hi ? wd : 32'h0,
                      w_oset_lo ? wd : 32'h0};
  wire [63:0] oclr = {w_oclr_hi ? wd : 32'h0,
                      w_oclr_lo ? wd : 32'h0};
  wire [63:0] dset = {w_dset_hi ? wd : 32'h0,
                      w_dset_lo ? wd : 32'h0};
  wire [63:0] dclr = {w_dclr_hi ? wd : 32'h0,
                      w_dclr_lo ? wd : 32'h0};
  wire [63:0] out_alias = (out_r | oset) & ~oclr;
  wire [63:0] dir_alias = (dir_r | dset) & ~dclr;

  assign out_nxt = {w_out_hi ? wd : out_alias[63:32],
                    w_out_lo ? wd : out_alias[31:0]};
  assign dir_nxt = {w_dir_hi ? wd : dir_alias[63:32],
                    w_dir_lo ? wd : dir_alias[31:0]};

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dir_r <= RST_DIR;
      out_r <= RST_OUT;
    end else begin
      dir_r <= dir_nxt;
      out_r <= out_nxt;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pen_r <= RST_PEN;
      src_r <= RST_ZERO;
      ppol_r <= RST_ZERO;
      sch_r <= RST_ZERO;
      hold_r <= RST_ZERO;
    end else begin
      if (w_pen_lo) pen_r[31:0] <= wd;
      if (w_pen_hi) pen_r[63:32] <= wd;
      if (w_src_lo) src_r[31:0] <= wd;
      if (w_src_hi) src_r[63:32] <= wd;
      if (w_ppol_lo) ppol_r[31:0] <= wd;
      if (w_ppol_hi) ppol_r[63:32] <= wd;
      if (w_sch_lo) sch_r[31:0] <= wd;
      if (w_sch_hi) sch_r[63:32] <= wd;
      if (w_hold_lo) hold_r[31:0] <= wd;
      if (w_hold_hi) hold_r[63:32] <= wd;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fn_r <= {2*GPR_PINS{1'b0}};
    end else begin
      if (w_fn0) fn_r[31:0] <= wd;
      if (w_fn1) fn_r[63:32] <= wd;
      if (w_fn2) fn_r[95:64] <= wd;
      if (w_fn3) fn_r[127:96] <= wd;
    end
  end

  // Per-pin pad decisions
  logic [63:0] is_gpio;
  logic [63:0] oe_nxt;
  logic [63:0] pull_nxt;
  genvar g;
  generate
    for (g = 0; g < GPR_PINS; g++) begin : g_pin
      assign is_gpio[g] = (fn_r[2*g +: 2] == FN_GPIO);
      assign oe_nxt[g] = is_gpio[g] && dir_r[g];
      // Alternate functions own their direction; only GPIO outputs
      // force the pull off here
      assign pull_nxt[g] = pen_r[g] && !oe_nxt[g];
    end
  endgenerate

  // Read mux; aliases read as zero
  logic [31:0] rd_nxt;
  always_comb begin
    rd_nxt = 32'h0;
    case (off)
      OFF_DIR_LO: rd_nxt = dir_r[31:0];
      OFF_DIR_HI: rd_nxt = dir_r[63:32];
      OFF_OUT_LO: rd_nxt = out_r[31:0];
      OFF_OUT_HI: rd_nxt = out_r[63:32];
      OFF_PEN_LO: rd_nxt = pen_r[31:0];
      OFF_PEN_HI: rd_nxt = pen_r[63:32];
      OFF_FN_Q0: rd_nxt = fn_r[31:0];
      OFF_FN_Q1: rd_nxt = fn_r[63:32];
      OFF_FN_Q2: rd_nxt = fn_r[95:64];
      OFF_FN_Q3: rd_nxt = fn_r[127:96];
      OFF_SRC_LO: rd_nxt = src_r[31:0];
      OFF_SRC_HI: rd_nxt = src_r[63:32];
      OFF_PPOL_LO: rd_nxt = ppol_r[31:0];
      OFF_PPOL_HI: rd_nxt = ppol_r[63:32];
      OFF_SCH_LO: rd_nxt = sch_r[31:0];
      OFF_SCH_HI: rd_nxt = sch_r[63:32];
      OFF_HOLD_LO: rd_nxt = hold_r[31:0];
      OFF_HOLD_HI: rd_nxt = hold_r[63:32];
      default: rd_nxt = 32'h0;
    endcase
  end

  // Registered outputs; pad follows register state one cycle later
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rsp <= '0;
      pad <= '0;
    end else begin
      rsp.rdata <= (in_bank && !req.wr) ? rd_nxt : 32'h0;
      // Stray access inside the window but off the map
      rsp.err <= req.sel && !in_bank &&
        (req.addr[31:7] == GPR_BASE[31:7]);
      pad.out_en <= oe_nxt;
      pad.out_val <= out_r & oe_nxt;
      pad.pull_en <= pull_nxt;
      pad.pull_up <= ppol_r;
      pad.schmitt <= sch_r;
      pad.holder <= hold_r;
      pad.alt_sel <= src_r;
      pad.func <= fn_r;
    end
  end

  // Pad checks that compare with $past skip the first edge after reset, where the pad flops
  // still hold their reset zeros
  a_pad_drive: assert property (
    @(posedge clock) disable iff (!rst_n)
    $past(rst_n) |-> pad.out_en == ($past(is_gpio) & $past(dir_r)))
    else $error("pad enable not from gpio direction");
  a_out_drive: assert property (
    @(posedge clock) disable iff (!rst_n)
    $past(rst_n) |-> pad.out_val == ($past(out_r) & pad.out_en))
    else $error("pad value not from output data");
  a_pull_off: assert property (
    @(posedge clock) disable iff (!rst_n)
    (pad.out_en & pad.pull_en) == 64'h0)
    else $error("pull on while driving");
  a_pull_input: assert property (
    @(posedge clock) disable iff (!rst_n)
    $past(rst_n) |-> pad.pull_en == ($past(pen_r) & ~pad.out_en))
    else $error("input pull not from pull enable");
  a_alt_block: assert property (
    @(posedge clock) disable iff (!rst_n)
    (fn_r[1:0] != FN_GPIO) |=> !pad.out_en[0])
    else $error("alternate pin driven by gpio");
  a_pad_copy: assert property (
    @(posedge clock) disable iff (!rst_n)
    $past(rst_n) |-> (pad.pull_up == $past(ppol_r)) &&
      (pad.schmitt == $past(sch_r)) && (pad.holder == $past(hold_r)) &&
      (pad.alt_sel == $past(src_r)) && (pad.func == $past(fn_r)))
    else $error("pad setting copy wrong");

  // Plain word writes land at the request edge
  a_dir_write: assert property (
    @(posedge clock) disable iff (!rst_n)
    w_dir_lo |=> dir_r[31:0] == $past(wd))
    else $error("direction write lost");
  a_dir_hi_write: assert property (
    @(posedge clock) disable iff (!rst_n)
    w_dir_hi |=> dir_r[63:32] == $past(wd))
    else $error("upper direction write lost");
  a_out_write: assert property (
    @(posedge clock) disable iff (!rst_n)
    w_out_lo |=> out_r[31:0] == $past(wd))
    else $error("output data write lost");
  a_out_hi_write: assert property (
    @(posedge clock) disable iff (!rst_n)
    w_out_hi |=> out_r[63:32] == $past(wd))
    else $error("upper output data write lost");
  a_pen_write: assert property (
    @(posedge clock) disable iff (!rst_n)
    w_pen_hi |=> pen_r[63:32] == $past(wd))
    else $error("pull enable write lost");
  a_pen_lo_write: assert property (
    @(posedge clock) disable iff (!rst_n)
    w_pen_lo |=> pen_r[31:0] == $past(wd))
    else $error("lower pull enable write lost");
  a_fn_write: assert property (
    @(posedge clock) disable iff (!rst_n)
    w_fn2 |=> fn_r[95:64] == $past(wd))
    else $error("function write lost");
  a_fn_q0_write: assert property (
    @(posedge clock) disable iff (!rst_n)
    w_fn0 |=> fn_r[31:0] == $past(wd))
    else $error("first function write lost");
  a_fn_q3_write: assert property (
    @(posedge clock) disable iff (!rst_n)
    w_fn3 |=> fn_r[127:96] == $past(wd))
    else $error("last function write lost");
  a_src_write: assert property (
    @(posedge clock) disable iff (!rst_n)
    w_src_lo |=> src_r[31:0] == $past(wd))
    else $error("data select write lost");
  a_ppol_write: assert property (
    @(posedge clock) disable iff (!rst_n)
    w_ppol_lo |=> ppol_r[31:0] == $past(wd))
    else $error("pull polarity write lost");
  a_sch_write: assert property (
    @(posedge clock) disable iff (!rst_n)
    w_sch_lo |=> sch_r[31:0] == $past(wd))
    else $error("hysteresis write lost");
  a_hold_write: assert property (
    @(posedge clock) disable iff (!rst_n)
    w_hold_lo |=> hold_r[31:0] == $past(wd))
    else $error("keeper write lost");

  // Aliases change only the bits written as one
  a_out_set: assert property (
    @(posedge clock) disable iff (!rst_n)
    w_oset_lo |=> ((out_r[31:0] & $past(wd)) == $past(wd)))
    else $error("data set missed bits");
  a_out_hi_set: assert property (
    @(posedge clock) disable iff (!rst_n)
    w_oset_hi |=> ((out_r[63:32] & $past(wd)) == $past(wd)))
    else $error("upper data set missed bits");
  a_out_clr: assert property (
    @(posedge clock) disable iff (!rst_n)
    w_oclr_hi |=> ((out_r[63:32] & $past(wd)) == 32'h0))
    else $error("data clear missed bits");
  a_out_lo_clr: assert property (
    @(posedge clock) disable iff (!rst_n)
    w_oclr_lo |=> ((out_r[31:0] & $past(wd)) == 32'h0))
    else $error("lower data clear missed bits");
  a_out_keep: assert property (
    @(posedge clock) disable iff (!rst_n)
    w_oclr_lo |=> ((out_r[31:0] & ~$past(wd))
      == ($past(out_r[31:0]) & ~$past(wd))))
    else $error("data clear touched zero bits");
  a_dir_set: assert property (
    @(posedge clock) disable iff (!rst_n)
    w_dset_lo |=> ((dir_r[31:0] & $past(wd)) == $past(wd)))
    else $error("direction set missed bits");
  a_dir_hi_set: assert property (
    @(posedge clock) disable iff (!rst_n)
    w_dset_hi |=> ((dir_r[63:32] & $past(wd)) == $past(wd)))
    else $error("upper direction set missed bits");
  a_dir_clr: assert property (
    @(posedge clock) disable iff (!rst_n)
    w_dclr_lo |=> ((dir_r[31:0] & $past(wd)) == 32'h0))
    else $error("direction clear missed bits");
  a_dir_hi_clr: assert property (
    @(posedge clock) disable iff (!rst_n)
    w_dclr_hi |=> ((dir_r[63:32] & $past(wd)) == 32'h0))
    else $error("upper direction clear missed bits");
  a_dir_keep: assert property (
    @(posedge clock) disable iff (!rst_n)
    w_dset_lo |=> ((dir_r[31:0] & ~$past(wd))
      == ($past(dir_r[31:0]) & ~$past(wd))))
    else $error("direction set touched zero bits");

  // Read data stands for the one cycle after the request edge
  a_alias_zero: assert property (
    @(posedge clock) disable iff (!rst_n)
    (in_bank && !req.wr && off >= OFF_OSET_LO) |=> rsp.rdata == 32'h0)
    else $error("write-only register read nonzero");
  a_dir_read: assert property (
    @(posedge clock) disable iff (!rst_n)
    (in_bank && !req.wr && off == OFF_DIR_HI) |=>
      rsp.rdata == $past(dir_r[63:32]))
    else $error("direction read wrong");
  a_out_read: assert property (
    @(posedge clock) disable iff (!rst_n)
    (in_bank && !req.wr && off == OFF_OUT_LO) |=>
      rsp.rdata == $past(out_r[31:0]))
    else $error("output data read wrong");
  a_rd_idle: assert property (
    @(posedge clock) disable iff (!rst_n)
    !(in_bank && !req.wr) |=> rsp.rdata == 32'h0)
    else $error("read data not idle zero");
  a_stray_err: assert property (
    @(posedge clock) disable iff (!rst_n)
    (req.sel && (req.addr[31:7] == GPR_BASE[31:7]) &&
      ((req.addr[1:0] != 2'h0) || (off > OFF_LAST))) |=> rsp.err)
    else $error("stray access not flagged");

  c_set_write: cover property (@(posedge clock) disable iff (!rst_n)
    w_oset_hi);
  c_drive_pin: cover property (@(posedge clock) disable iff (!rst_n)
    w_dir_lo ##2 pad.out_en[0]);
  c_alt_mode: cover property (@(posedge clock) disable iff (!rst_n)
    w_fn0 ##1 fn_r[1:0] != FN_GPIO);
  c_bad_addr: cover property (@(posedge clock) disable iff (!rst_n)
    rsp.err);
  c_read_back: cover property (@(posedge clock) disable iff (!rst_n)
    (in_bank && !req.wr) ##1 (rsp.rdata != 32'h0));
endmodule : gpr_bank

// *** test/gpr_pad_model.sv ***
// Off-chip pad model: resolves each pad level
`timescale 1ns/1ns
module gpr_pad_model
  import gpr_pkg::*;
(
  input gpr_pad_t pad,
  input wire logic [63:0] ext_val,
  output logic [63:0] level
);
  // Driven pads win, else the pull, else the outside world
  assign level = (pad.out_en & pad.out_val)
    | (~pad.out_en & pad.pull_en & pad.pull_up)
    | (~pad.out_en & ~pad.pull_en & ext_val);
endmodule : gpr_pad_model

// *** test/tb_gpr_bank.sv ***
// Testbench for the pad register bank
`timescale 1ns/1ns
module tb_gpr_bank;
  import gpr_pkg::*;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  gpr_req_t req = '0;
  gpr_rsp_t rsp;
  gpr_pad_t pad;
  logic [63:0] ext_val = 64'h10;
  logic [63:0] level;
  logic [31:0] rd;
  logic err;
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;

  gpr_bank u_dut (.clock(clock), .nrst(nrst), .req(req), .rsp(rsp),
    .pad(pad));
  gpr_pad_model u_pads (.pad(pad), .ext_val(ext_val), .level(level));

  initial begin
    forever #10 clock = ~clock;
  end

  task report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop

  // Whole run needs under two hundred cycles
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      $display("BAD %0t run timed out", $time);
      report_and_stop;
    end
  end

  task chk(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One word access; sel held for exactly one taken edge, answer
  // taken while it stands in the following cycle
  task acc(input logic wr, input logic [6:0] off, input logic [31:0] wd);
    @(negedge clock);
    req = '{sel: 1'b1, wr: wr, addr: GPR_BASE | {25'h0, off},
      wdata: wd};
    @(negedge clock);
    rd = rsp.rdata;
    err = rsp.err;
    req.sel = 1'b0;
  endtask : acc

  task rd_chk(input logic [6:0] off, input logic [31:0] exp);
    acc(1'b0, off, 32'h0);
    chk({32'h0, rd}, {32'h0, exp});
  endtask : rd_chk

  // Pad outputs trail the register by one more edge
  task settle;
    @(posedge clock);
    #1;
  endtask : settle

  task t_reset;
    chk(pad.out_en, RST_DIR);
    chk(pad.out_val, RST_OUT);
    chk(pad.pull_en, RST_PEN & ~RST_DIR);
    chk(pad.func[63:0], 64'h0);
    rd_chk(OFF_DIR_LO, 32'h03c0_0000);
    rd_chk(OFF_OUT_LO, 32'h03c0_0000);
    rd_chk(OFF_DIR_HI, 32'h0);
    rd_chk(OFF_PEN_HI, 32'hffff_ffff);
    rd_chk(OFF_FN_Q3, 32'h0);
    $display("test reset done");
  endtask : t_reset

  task t_rw;
    for (int i = 0; i < 18; i++) begin
      acc(1'b1, 7'(i * 4), 32'h5a00_0000 | i);
    end
    for (int i = 0; i < 18; i++) begin
      rd_chk(7'(i * 4), 32'h5a00_0000 | i);
    end
    chk({32'h0, pad.alt_sel[31:0]}, 64'h5a00_000a);
    chk({32'h0, pad.pull_up[63:32]}, 64'h5a00_000d);
    chk({32'h0, pad.schmitt[31:0]}, 64'h5a00_000e);
    chk({32'h0, pad.holder[63:32]}, 64'h5a00_0011);
    $display("test read write done");
  endtask : t_rw

  task t_setclr;
    acc(1'b1, OFF_OUT_LO, 32'h0);
    acc(1'b1, OFF_OSET_LO, 32'h8000_0011);
    rd_chk(OFF_OUT_LO, 32'h8000_0011);
    acc(1'b1, OFF_OCLR_LO, 32'h1);
    rd_chk(OFF_OUT_LO, 32'h8000_0010);
    acc(1'b1, OFF_OUT_HI, 32'hf0);
    acc(1'b1, OFF_OSET_HI, 32'h1);
    acc(1'b1, OFF_OCLR_HI, 32'h10);
    rd_chk(OFF_OUT_HI, 32'he1);
    acc(1'b1, OFF_DIR_LO, 32'h0);
    acc(1'b1, OFF_DSET_LO, 32'h3);
    acc(1'b1, OFF_DCLR_LO, 32'h2);
    rd_chk(OFF_DIR_LO, 32'h1);
    acc(1'b1, OFF_DIR_HI, 32'hff);
    acc(1'b1, OFF_DCLR_HI, 32'h0f);
    acc(1'b1, OFF_DSET_HI, 32'h100);
    rd_chk(OFF_DIR_HI, 32'h1f0);
    rd_chk(OFF_DSET_LO, 32'h0);
    rd_chk(OFF_OCLR_HI, 32'h0);
    $display("test set clear done");
  endtask : t_setclr

  task t_pads;
    acc(1'b1, OFF_FN_Q0, 32'h0);
    acc(1'b1, OFF_PEN_LO, 32'hffff_ffef);
    acc(1'b1, OFF_PPOL_LO, 32'h6);
    acc(1'b1, OFF_OUT_LO, 32'h1);
    acc(1'b1, OFF_DIR_LO, 32'h3);
    settle;
    chk({32'h0, pad.out_en[31:0]}, 64'h3);
    chk({32'h0, pad.pull_en[31:0]}, 64'hffff_ffec);
    chk({59'h0, level[4:0]}, 64'h15);
    acc(1'b1, OFF_FN_Q0, 32'h1);
    acc(1'b1, OFF_FN_Q3, 32'hc000_0000);
    settle;
    chk({62'h0, pad.out_en[1:0]}, 64'h2);
    chk({63'h0, pad.pull_en[0]}, 64'h1);
    chk({62'h0, pad.func[1:0]}, 64'h1);
    chk({62'h0, pad.func[127:126]}, 64'h3);
    $display("test pads done");
  endtask : t_pads

  task t_bad;
    acc(1'b0, 7'h68, 32'h0);
    chk({63'h0, err}, 64'h1);
    chk({32'h0, rd}, 64'h0);
    acc(1'b0, 7'h02, 32'h0);
    chk({63'h0, err}, 64'h1);
    $display("test bad address done");
  endtask : t_bad

  initial begin
    repeat (16) @(posedge clock);
    @(negedge clock);
    nrst = 1'b1;
    repeat (3) @(posedge clock);
    #1;
    t_reset;
    t_rw;
    t_setclr;
    t_pads;
    t_bad;
    report_and_stop;
  end
endmodule : tb_gpr_bank
